// ===== include/swb_pkg.sv
package swb_pkg;

    // Opcode of the instruction in the upper six bits of the instruction word.
    localparam logic [5:0]  OPCODE          = 6'h15;
    localparam int          OPCODE_MSB      = 15;
    localparam int          OPCODE_LSB      = 10;
    localparam int          DEST_BIT        = 9;
    localparam int          ACCESS_BIT      = 8;
    localparam int          FILE_MSB        = 7;

    // Data memory addressing.
    localparam int          DATA_W          = 8;
    localparam int          ADDR_W          = 12;
    localparam int          BANK_W          = 4;
    localparam logic [7:0]  ACCESS_SPLIT    = 8'h60;
    localparam logic [7:0]  INDEX_LIMIT     = 8'h5f;
    localparam logic [3:0]  ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0]  ACCESS_SFR_BANK = 4'hf;

    // Flag positions in the status byte.
    localparam int          FLAG_C          = 0;
    localparam int          FLAG_DIG_CARRY  = 1;
    localparam int          FLAG_Z          = 2;
    localparam int          FLAG_OVERFLOW   = 3;
    localparam int          FLAG_N          = 4;
    localparam int          FLAG_W          = 5;

    // Reset values.
    localparam logic [7:0]  WREG_RESET      = 8'h00;
    localparam logic [4:0]  FLAGS_RESET     = 5'h00;

    // Quarter cycle sequence of one instruction cycle.
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DECODE,
        ST_READ,
        ST_PROCESS,
        ST_WRITE
    } swb_state_type;

endpackage

// ===== verilog/swb_exec.sv
// Functional notes
// (RULE_01) Result is W minus f minus borrow.
// (RULE_02) Destination bit zero writes W, one writes f.
// (RULE_03) Access bit zero uses access bank, else bank.
// (RULE_04) Extended set, access zero, f<=95: indexed offset.
// (RULE_05) Update all five flags; carry means no borrow.
// (RULE_06) One cycle: decode, read, process, write last.
`timescale 1ns/1ps

module swb_exec (
    input  wire logic        core_clk_in,          // Core clock, 250 MHz.
    input  wire logic        reset_in,             // Synchronous reset, active high.
    input  wire logic        instr_valid_in,       // Instruction word present, taken in idle.
    input  wire logic [15:0] instr_in,             // Instruction word.
    input  wire logic        ext_set_en_in,        // Extended instruction set enabled.
    input  wire logic [3:0]  bank_select_in,       // Bank select register value.
    input  wire logic [11:0] index_base_in,        // Base pointer for indexed literal offset.
    input  wire logic [7:0]  file_rdata_in,        // File register data, one cycle after read.
    input  wire logic        wreg_load_in,         // Load working register from outside.
    input  wire logic [7:0]  wreg_value_in,        // Value for working register load.
    input  wire logic        flags_load_in,        // Load status flags from outside.
    input  wire logic [4:0]  flags_value_in,       // Flags negative, overflow, zero, digit carry, carry.
    output logic             busy_out,             // Instruction in progress.
    output logic [11:0]      file_addr_out,        // File register address.
    output logic             file_rd_out,          // File register read strobe.
    output logic             file_wr_out,          // File register write strobe.
    output logic [7:0]       file_wdata_out,       // File register write data.
    output logic [7:0]       wreg_out,             // Working register.
    output logic [4:0]       flags_out,            // Flags negative, overflow, zero, digit carry, carry.
    output logic             done_out,             // Pulse in the write quarter.
    output logic             reject_out            // Pulse when a foreign opcode is offered in idle.
);

    typedef struct packed {
        swb_pkg::swb_state_type state;
        logic                   busy;
        logic                   dest_file;
        logic [11:0]            addr;
        logic                   rd;
        logic                   wr;
        logic [7:0]             wdata;
        logic [7:0]             wreg;
        logic [4:0]             flags;
        logic                   done;
        logic                   reject;
    } swb_regs_type;

    swb_regs_type r;
    swb_regs_type next_r;

    logic [7:0] file_field;
    logic       access_bit;
    logic [8:0] full_sum;
    logic [4:0] nib_sum;
    logic [7:0] result;

    // Instruction fields of the offered word.
    assign file_field = instr_in[swb_pkg::FILE_MSB:0];
    assign access_bit = instr_in[swb_pkg::ACCESS_BIT];

    // Subtraction as W plus inverted f plus carry, so carry out means no borrow.
    assign full_sum = {1'b0, r.wreg} + {1'b0, ~file_rdata_in} + {8'h00, r.flags[swb_pkg::FLAG_C]}; // see RULE_01
    assign nib_sum  = {1'b0, r.wreg[3:0]} + {1'b0, ~file_rdata_in[3:0]}
                    + {4'h0, r.flags[swb_pkg::FLAG_C]}; // see RULE_05
    assign result   = full_sum[7:0];

    // Next state of the whole datapath.
    always_comb begin
        next_r        = r;
        next_r.rd     = 1'b0;
        next_r.wr     = 1'b0;
        next_r.done   = 1'b0;
        next_r.reject = 1'b0;
        if (wreg_load_in && r.state == swb_pkg::ST_IDLE) begin
            next_r.wreg = wreg_value_in;
        end
        if (flags_load_in && r.state == swb_pkg::ST_IDLE) begin
            next_r.flags = flags_value_in;
        end
        case (r.state)
            swb_pkg::ST_IDLE: begin
                if (instr_valid_in) begin
                    if (instr_in[swb_pkg::OPCODE_MSB:swb_pkg::OPCODE_LSB] == swb_pkg::OPCODE) begin
                        next_r.state     = swb_pkg::ST_DECODE; // see RULE_06
                        next_r.busy      = 1'b1;
                        next_r.dest_file = instr_in[swb_pkg::DEST_BIT];
                        if (access_bit) begin
                            next_r.addr = {bank_select_in, file_field}; // see RULE_03
                        end else if (ext_set_en_in && file_field <= swb_pkg::INDEX_LIMIT) begin
                            next_r.addr = index_base_in + {4'h0, file_field}; // see RULE_04
                        end else if (file_field < swb_pkg::ACCESS_SPLIT) begin
                            next_r.addr = {swb_pkg::ACCESS_LOW_BANK, file_field}; // see RULE_03
                        end else begin
                            next_r.addr = {swb_pkg::ACCESS_SFR_BANK, file_field}; // see RULE_03
                        end
                    end else begin
                        next_r.reject = 1'b1;
                    end
                end
            end
            swb_pkg::ST_DECODE: begin
                next_r.state = swb_pkg::ST_READ;
                next_r.rd    = 1'b1; // see RULE_06
            end
            swb_pkg::ST_READ: begin
                next_r.state = swb_pkg::ST_PROCESS;
            end
            swb_pkg::ST_PROCESS: begin
                next_r.state                          = swb_pkg::ST_WRITE;
                next_r.done                           = 1'b1;
                next_r.flags[swb_pkg::FLAG_C]         = full_sum[8]; // see RULE_05
                next_r.flags[swb_pkg::FLAG_DIG_CARRY] = nib_sum[4]; // see RULE_05
                next_r.flags[swb_pkg::FLAG_Z]         = (result == 8'h00); // see RULE_05
                next_r.flags[swb_pkg::FLAG_N]         = result[7]; // see RULE_05
                next_r.flags[swb_pkg::FLAG_OVERFLOW]  = (r.wreg[7] != file_rdata_in[7])
                                                      && (result[7] != r.wreg[7]); // see RULE_05
                if (r.dest_file) begin
                    next_r.wr    = 1'b1; // see RULE_02
                    next_r.wdata = result;
                end else begin
                    next_r.wreg  = result; // see RULE_02
                end
            end
            swb_pkg::ST_WRITE: begin
                next_r.state = swb_pkg::ST_IDLE;
                next_r.busy  = 1'b0; // see RULE_06
            end
            default: begin
                next_r.state = swb_pkg::ST_IDLE;
                next_r.busy  = 1'b0;
            end
        endcase
    end

    // State register with synchronous reset.
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            r.state      <= swb_pkg::ST_IDLE;
            r.busy       <= 1'b0;
            r.dest_file  <= 1'b0;
            r.addr       <= 12'h000;
            r.rd         <= 1'b0;
            r.wr         <= 1'b0;
            r.wdata      <= 8'h00;
            r.wreg       <= swb_pkg::WREG_RESET;
            r.flags      <= swb_pkg::FLAGS_RESET;
            r.done       <= 1'b0;
            r.reject     <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    // Outputs come straight from the state register.
    assign busy_out       = r.busy;
    assign file_addr_out  = r.addr;
    assign file_rd_out    = r.rd;
    assign file_wr_out    = r.wr;
    assign file_wdata_out = r.wdata;
    assign wreg_out       = r.wreg;
    assign flags_out      = r.flags;
    assign done_out       = r.done;
    assign reject_out     = r.reject;

    // Helper copies of the sampled operands for the checks below.
    logic [7:0] chk_w;
    logic [7:0] chk_f;
    logic       chk_c;
    always_ff @(posedge core_clk_in) begin
        if (r.state == swb_pkg::ST_PROCESS) begin
            chk_w <= r.wreg;
            chk_f <= file_rdata_in;
            chk_c <= r.flags[swb_pkg::FLAG_C];
        end
    end

    result_value_a: assert property (@(posedge core_clk_in) disable iff (reset_in) // see RULE_01
        done_out |-> ((file_wr_out ? file_wdata_out : wreg_out) == 8'(chk_w - chk_f - {7'h00, ~chk_c})))
        else $error("Result differs from W minus f minus borrow.");

    dest_file_a: assert property (@(posedge core_clk_in) disable iff (reset_in) // see RULE_02
        (r.state == swb_pkg::ST_PROCESS && r.dest_file) |=> (file_wr_out && wreg_out == $past(r.wreg)))
        else $error("File destination did not write file or touched W.");

    dest_wreg_a: assert property (@(posedge core_clk_in) disable iff (reset_in) // see RULE_02
        (r.state == swb_pkg::ST_PROCESS && !r.dest_file) |=> !file_wr_out)
        else $error("W destination wrote the file register.");

    bank_addr_a: assert property (@(posedge core_clk_in) disable iff (reset_in) // see RULE_03
        (r.state == swb_pkg::ST_IDLE && instr_valid_in && instr_in[15:10] == swb_pkg::OPCODE && instr_in[8])
        |=> file_addr_out == {$past(bank_select_in), $past(instr_in[7:0])})
        else $error("Bank addressing used a wrong address.");

    indexed_addr_a: assert property (@(posedge core_clk_in) disable iff (reset_in) // see RULE_04
        (r.state == swb_pkg::ST_IDLE && instr_valid_in && instr_in[15:10] == swb_pkg::OPCODE && !instr_in[8]
         && ext_set_en_in && instr_in[7:0] <= 8'h5f)
        |=> file_addr_out == 12'($past(index_base_in) + {4'h0, $past(instr_in[7:0])}))
        else $error("Indexed literal offset address is wrong.");

    // Plain access bank: low part of the bank below the split, upper bank above it.
    access_bank_a: assert property (@(posedge core_clk_in) disable iff (reset_in) // see RULE_03
        (r.state == swb_pkg::ST_IDLE && instr_valid_in && instr_in[15:10] == swb_pkg::OPCODE && !instr_in[8]
         && !(ext_set_en_in && instr_in[7:0] <= 8'h5f))
        |=> file_addr_out == {(($past(instr_in[7:0]) < 8'h60) ? 4'h0 : 4'hf), $past(instr_in[7:0])})
        else $error("Access bank addressing used a wrong address.");

    zero_neg_a: assert property (@(posedge core_clk_in) disable iff (reset_in) // see RULE_05
        done_out |-> (flags_out[swb_pkg::FLAG_Z] == ((file_wr_out ? file_wdata_out : wreg_out) == 8'h00))
                  && (flags_out[swb_pkg::FLAG_N] == (file_wr_out ? file_wdata_out[7] : wreg_out[7])))
        else $error("Zero or negative flag disagrees with the result.");

    carry_flag_a: assert property (@(posedge core_clk_in) disable iff (reset_in) // see RULE_05
        done_out |-> flags_out[swb_pkg::FLAG_C] == ({1'b0, chk_w} >= ({1'b0, chk_f} + {8'h00, ~chk_c})))
        else $error("Carry does not show absence of borrow.");

    one_cycle_a: assert property (@(posedge core_clk_in) disable iff (reset_in) // see RULE_06
        (r.state == swb_pkg::ST_IDLE && instr_valid_in && instr_in[15:10] == swb_pkg::OPCODE)
        |=> busy_out ##1 file_rd_out ##1 !file_rd_out ##1 done_out ##1 !busy_out)
        else $error("Quarter cycle sequence broken.");

    file_dest_cov: cover property (@(posedge core_clk_in) file_wr_out && done_out);
    wreg_dest_cov: cover property (@(posedge core_clk_in) done_out && !file_wr_out);
    zero_res_cov:  cover property (@(posedge core_clk_in) done_out && flags_out[swb_pkg::FLAG_Z]);
    reject_cov:    cover property (@(posedge core_clk_in) reject_out && !busy_out);
    indexed_cov:   cover property (@(posedge core_clk_in) r.state == swb_pkg::ST_IDLE && instr_valid_in
                                   && ext_set_en_in && !instr_in[8] && instr_in[7:0] <= 8'h5f);

endmodule

// ===== tb/tb_top.sv
`timescale 1ns/1ps

module tb_top;
    logic        core_clk_in    = 1'b0;
    logic        reset_in       = 1'b1;
    logic        instr_valid_in = 1'b0;
    logic [15:0] instr_in       = 16'h0000;
    logic        ext_set_en_in  = 1'b0;
    logic [3:0]  bank_select_in = 4'h0;
    logic [11:0] index_base_in  = 12'h000;
    logic [7:0]  file_rdata_in  = 8'h00;
    logic        wreg_load_in   = 1'b0;
    logic [7:0]  wreg_value_in  = 8'h00;
    logic        flags_load_in  = 1'b0;
    logic [4:0]  flags_value_in = 5'h00;
    logic        busy_out;
    logic [11:0] file_addr_out;
    logic        file_rd_out;
    logic        file_wr_out;
    logic [7:0]  file_wdata_out;
    logic [7:0]  wreg_out;
    logic [4:0]  flags_out;
    logic        done_out;
    logic        reject_out;
    int          fail_count     = 0;
    int          tests_run      = 0;

    // Free running core clock, 4 ns period.
    always #2 core_clk_in = ~core_clk_in;

    swb_exec dut_u (.core_clk_in(core_clk_in), .reset_in(reset_in), .instr_valid_in(instr_valid_in),
        .instr_in(instr_in), .ext_set_en_in(ext_set_en_in), .bank_select_in(bank_select_in),
        .index_base_in(index_base_in), .file_rdata_in(file_rdata_in), .wreg_load_in(wreg_load_in),
        .wreg_value_in(wreg_value_in), .flags_load_in(flags_load_in), .flags_value_in(flags_value_in),
        .busy_out(busy_out), .file_addr_out(file_addr_out), .file_rd_out(file_rd_out),
        .file_wr_out(file_wr_out), .file_wdata_out(file_wdata_out), .wreg_out(wreg_out),
        .flags_out(flags_out), .done_out(done_out), .reject_out(reject_out));

    // Compares one observed value with its expectation and counts the outcome.
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Runs one instruction through its whole walk and judges every quarter.
    task automatic run_op(input logic d, input logic a, input logic ext, input logic [7:0] f,
                          input logic [7:0] w, input logic [7:0] fd, input logic cin,
                          input logic [3:0] bank, input logic [11:0] base);
        logic [11:0] ea;
        logic [8:0]  r;
        logic [4:0]  h;
        logic [4:0]  fl;
        r  = {1'b0, w} - {1'b0, fd} - {8'h00, ~cin};
        h  = {1'b0, w[3:0]} - {1'b0, fd[3:0]} - {4'h0, ~cin};
        fl = {r[7], (w[7] != fd[7]) && (r[7] != w[7]), r[7:0] == 8'h00, ~h[4], ~r[8]};
        ea = a ? {bank, f} : (ext && f <= 8'h5f) ? base + {4'h0, f} : (f < 8'h60) ? {4'h0, f} : {4'hf, f};
        @(negedge core_clk_in);
        wreg_load_in   = 1'b1;
        wreg_value_in  = w;
        flags_load_in  = 1'b1;
        flags_value_in = {4'ha, cin};
        @(negedge core_clk_in);
        wreg_load_in   = 1'b0;
        flags_load_in  = 1'b0;
        instr_valid_in = 1'b1;
        instr_in       = {swb_pkg::OPCODE, d, a, f};
        ext_set_en_in  = ext;
        bank_select_in = bank;
        index_base_in  = base;
        file_rdata_in  = ~fd;
        @(negedge core_clk_in);
        instr_valid_in = 1'b0;
        chk("busy", {15'h0, busy_out}, 16'h1);
        chk("addr", {4'h0, file_addr_out}, {4'h0, ea});
        @(negedge core_clk_in);
        chk("rd", {15'h0, file_rd_out}, 16'h1);
        file_rdata_in = fd;
        @(negedge core_clk_in);
        chk("done_early", {15'h0, done_out}, 16'h0);
        @(negedge core_clk_in);
        file_rdata_in = ~fd;
        chk("done", {15'h0, done_out}, 16'h1);
        chk("wr", {15'h0, file_wr_out}, {15'h0, d});
        if (d) begin
            chk("wdata", {8'h0, file_wdata_out}, {8'h0, r[7:0]});
        end
        chk("wreg", {8'h0, wreg_out}, {8'h0, d ? w : r[7:0]});
        chk("flags", {11'h0, flags_out}, {11'h0, fl});
        @(negedge core_clk_in);
        chk("idle", {15'h0, busy_out}, 16'h0);
    endtask

    // Offers a foreign opcode and expects only a refusal pulse.
    task automatic run_reject();
        @(negedge core_clk_in);
        instr_valid_in = 1'b1;
        instr_in       = 16'h5123;
        @(negedge core_clk_in);
        instr_valid_in = 1'b0;
        chk("reject", {15'h0, reject_out}, 16'h1);
        chk("rej_busy", {15'h0, busy_out}, 16'h0);
    endtask

    // Cuts an instruction short with a reset and expects the reset values.
    task automatic run_mid_reset();
        @(negedge core_clk_in);
        instr_valid_in = 1'b1;
        instr_in       = {swb_pkg::OPCODE, 1'b1, 1'b1, 8'h33};
        bank_select_in = 4'h2;
        @(negedge core_clk_in);
        instr_valid_in = 1'b0;
        chk("mid_busy", {15'h0, busy_out}, 16'h1);
        chk("mid_addr", {4'h0, file_addr_out}, 16'h0233);
        reset_in = 1'b1;
        @(negedge core_clk_in);
        reset_in = 1'b0;
        chk("mid_rst_busy", {15'h0, busy_out}, 16'h0);
        chk("mid_rst_addr", {4'h0, file_addr_out}, 16'h0000);
        chk("mid_rst_rd", {15'h0, file_rd_out}, 16'h0);
        chk("mid_rst_wreg", {8'h0, wreg_out}, {8'h0, swb_pkg::WREG_RESET});
        chk("mid_rst_flags", {11'h0, flags_out}, {11'h0, swb_pkg::FLAGS_RESET});
    endtask

    // Watchdog that cuts a hang short; the scenarios need well under a tenth of this span.
    initial begin
        #20000;
        fail_count++;
        stop_test();
    end

    // Main sequence: reset, then the scenarios.
    initial begin
        repeat (10) @(posedge core_clk_in);
        @(negedge core_clk_in);
        reset_in = 1'b0;
        chk("rst_wreg", {8'h0, wreg_out}, 16'h0);
        chk("rst_flags", {11'h0, flags_out}, 16'h0);
        run_op(1'b1, 1'b0, 1'b0, 8'h20, 8'h02, 8'h03, 1'b1, 4'h0, 12'h000);
        run_op(1'b0, 1'b0, 1'b0, 8'h5f, 8'h05, 8'h02, 1'b1, 4'h0, 12'h000);
        run_op(1'b1, 1'b0, 1'b0, 8'h60, 8'h02, 8'h01, 1'b0, 4'h0, 12'h000);
        run_op(1'b0, 1'b1, 1'b1, 8'h10, 8'h80, 8'h01, 1'b1, 4'h7, 12'h000);
        run_op(1'b0, 1'b0, 1'b1, 8'h5f, 8'h10, 8'h01, 1'b0, 4'h3, 12'hffe);
        run_op(1'b1, 1'b0, 1'b1, 8'h60, 8'h7f, 8'hff, 1'b1, 4'h3, 12'h100);
        run_mid_reset();
        run_op(1'b0, 1'b0, 1'b0, 8'h10, 8'h05, 8'h05, 1'b1, 4'h0, 12'h000);
        run_reject();
        stop_test();
    end
endmodule
